// >>> core/dbg_cfg.svh
// Purpose: constants for the on-chip debug and trace unit
// Assumes: 40 MHz core clock, serial scan link on its own clock
// Notes: register offsets are word indices (haddr[7:2]) on the AHB-Lite port
//
// Functional notes
// - by default the debug logic touches the internal bus only when the cpu is not using it.
// - in priority mode the debug logic may stall a cpu memory access for one cycle.
// - debug data moves between cpu resources and the emulator while the cpu keeps running.
// - the scan path runs only through this block, which fetches on-chip data by itself.
// - there are two interrupt environments, normal and emulation, chosen by program settings.
// - while the main program is halted, enabled interrupts are still taken and serviced.
// - interrupt entry saves the debug-enable state and the return restores it.
// - selected debug control registers are readable and writable by cpu software.
// - a halt request lets instructions already in the pipeline finish before stalling.
// - sequential trace keeps the most recent 32 program-counter values.
// - discontinuity trace keeps the most recent 16 program-counter discontinuities.
// - the emulator picks at run time what trace data is exported and in which format.
// - a real-time data channel shares the debug path and moves at most 2M bytes per second from the cpu to the host.
`ifndef DBG_CFG_SVH
`define DBG_CFG_SVH

// ----------------------------------------------------------------
// scan frame layout
// ----------------------------------------------------------------
`define DBG_FRAME_BITS 48
`define DBG_CMD_LSB 0
`define DBG_ADDR_LSB 4
`define DBG_DATA_LSB 16
`define DBG_CNT_LAST 6'd47

// ----------------------------------------------------------------
// scan commands
// ----------------------------------------------------------------
`define DBG_CMD_NOP 4'h0
`define DBG_CMD_MEM_RD 4'h1
`define DBG_CMD_MEM_WR 4'h2
`define DBG_CMD_HALT 4'h3
`define DBG_CMD_RUN 4'h4
`define DBG_CMD_TRACE_RD 4'h5
`define DBG_CMD_CFG 4'h6
`define DBG_CMD_CHAN_RD 4'h7
`define DBG_CMD_CHAN_WR 4'h8
`define DBG_CMD_STATUS 4'h9

// ----------------------------------------------------------------
// register map and fields
// ----------------------------------------------------------------
`define DBG_REG_CTRL 6'h00
`define DBG_REG_STATUS 6'h01
`define DBG_REG_MASK_NORM 6'h02
`define DBG_REG_MASK_EMU 6'h03
`define DBG_REG_CHAN_TX 6'h04
`define DBG_REG_CHAN_RX 6'h05
`define DBG_CTRL_EN 0
`define DBG_CTRL_PRIO 1
`define DBG_CTRL_ENV 2
`define DBG_CFG_TEN 0
`define DBG_CFG_TMODE 1
`define DBG_CFG_TFMT 2

// ----------------------------------------------------------------
// trace depths and channel pacing
// ----------------------------------------------------------------
`define DBG_SEQ_DEPTH 6'd32
`define DBG_DISC_DEPTH 6'd16
`define DBG_CLK_HZ 40000000
`define DBG_CHAN_BYTES_PER_S 2000000
`define DBG_CHAN_WORD_CYCLES \
  ((`DBG_CLK_HZ * 4 + `DBG_CHAN_BYTES_PER_S - 1) / `DBG_CHAN_BYTES_PER_S)

`endif

// >>> core/dbg_pkg.sv
// Purpose: types shared by the debug and trace unit
// Assumes: constants from dbg_cfg.svh
// Notes: link state and core state are kept in separate structs
`include "dbg_cfg.svh"
package dbg_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_RDATA} core_state_e;
  // link side: shifter, latched command, toggles
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [47:0] sr;
    logic [47:0] word;
    logic [5:0] cnt;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic [32:0] out_sr;
  } link_s;
  // core side
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic ack_tgl;
    core_state_e state;
    logic [47:0] cmd;
    logic [31:0] result;
    logic dbg_en;
    logic prio;
    logic env_sel;
    logic saved_en;
    logic isr_act;
    logic halt_req;
    logic halted;
    logic [7:0] mask_norm;
    logic [7:0] mask_emu;
    logic ten;
    logic tmode;
    logic tfmt;
    logic [4:0] wptr;
    logic [5:0] tcnt;
    logic [31:0] tx_word;
    logic tx_full;
    logic [31:0] rx_word;
    logic rx_full;
    logic [7:0] pace;
    logic ahb_wr;
    logic [5:0] ahb_idx;
    logic [31:0] hrdata;
  } core_s;
endpackage

// >>> core/onchip_debug_trace_unit.sv
// Purpose: on-chip debug unit: scan command port, bus access, halt, trace
// Assumes: cpu signals on clk; scan pins on tck, which may stop between frames
// Notes: one 48-bit frame per command; the answer leaves in the next frame
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "dbg_cfg.svh"
module onchip_debug_trace_unit #(
  parameter int PC_W = 24,
  parameter int IRQ_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // scan link
  input wire logic tck,
  input wire logic scan_sel,
  input wire logic scan_in,
  output logic scan_out,
  // on-chip memory bus shared with the cpu
  input wire logic cpu_bus_busy,
  output logic cpu_stall,
  output logic mem_req,
  output logic mem_we,
  output logic [11:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  // pipeline control
  input wire logic pipe_empty,
  output logic fetch_hold,
  output logic pipe_stall,
  // interrupts
  input wire logic [IRQ_W-1:0] irq_pend,
  output logic irq_take,
  input wire logic isr_entry,
  input wire logic isr_return,
  // program counter stream
  input wire logic pc_valid,
  input wire logic pc_disc,
  input wire logic [PC_W-1:0] pc
);

  dbg_pkg::link_s lk;
  dbg_pkg::link_s next_lk;
  dbg_pkg::core_s st;
  dbg_pkg::core_s next_st;
  logic [PC_W-1:0] trace_mem [0:31];
  logic link_busy;
  logic req_new;
  logic [3:0] cmd_code;
  logic [5:0] depth;
  logic trace_rec;
  logic [4:0] rd_slot;
  logic [5:0] rd_idx;
  logic [31:0] trace_word;
  logic [31:0] status_word;
  logic ahb_take;

  // slot of an entry by age, 0 newest; wraps at the active depth
  function automatic logic [4:0] age_slot(input logic [4:0] wp, input logic [5:0] age,
                                          input logic [5:0] dep);
    logic [5:0] s;
    s = {1'b0, wp} + dep - 6'd1 - age;
    if (s >= dep)
    begin
      s = s - dep;
    end
    return s[4:0];
  endfunction

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  assign link_busy = lk.req_tgl != lk.ack_s2;
  assign scan_out = lk.out_sr[0];

  // frame shifter; the only path the emulator scans through
  always_comb
  begin
    next_lk = lk;
    next_lk.rst_s1 = rstn;
    next_lk.rst_s2 = lk.rst_s1;
    next_lk.ack_s1 = st.ack_tgl;
    next_lk.ack_s2 = lk.ack_s1;
    if (!lk.rst_s2)
    begin
      next_lk.sr = '0;
      next_lk.word = '0;
      next_lk.cnt = '0;
      next_lk.req_tgl = 1'b0;
      next_lk.out_sr = '0;
    end
    else if (!scan_sel)
    begin
      next_lk.cnt = '0; // partial frame dropped
    end
    else
    begin
      next_lk.sr = {scan_in, lk.sr[47:1]};
      // result is stable once ack matches, so it may be sampled here
      if (lk.cnt == 6'd0)
      begin
        next_lk.out_sr = {link_busy, st.result};
      end
      else
      begin
        next_lk.out_sr = {1'b0, lk.out_sr[32:1]};
      end
      if (lk.cnt == `DBG_CNT_LAST)
      begin
        next_lk.cnt = '0;
        // a frame arriving while busy is dropped, not queued
        if (!link_busy)
        begin
          next_lk.word = {scan_in, lk.sr[47:1]};
          next_lk.req_tgl = ~lk.req_tgl;
        end
      end
      else
      begin
        next_lk.cnt = lk.cnt + 6'd1;
      end
    end
  end

  // reset synchroniser flops carry no reset of their own
  always_ff @(posedge tck)
  begin
    lk <= next_lk;
  end

  // ----------------------------------------------------------------
  // core domain: decode helpers
  // ----------------------------------------------------------------
  assign req_new = (st.req_s2 != st.ack_tgl) && (st.state == dbg_pkg::ST_IDLE);
  assign cmd_code = st.cmd[`DBG_CMD_LSB +: 4];
  assign depth = st.tmode ? `DBG_DISC_DEPTH : `DBG_SEQ_DEPTH;
  assign trace_rec = st.ten && st.dbg_en && pc_valid && (!st.tmode || pc_disc);
  assign rd_idx = lk.word[`DBG_ADDR_LSB +: 6];
  assign rd_slot = age_slot(st.wptr, rd_idx, depth);
  // export format picked by the emulator
  always_comb
  begin
    trace_word = '0;
    if (rd_idx < st.tcnt)
    begin
      trace_word[PC_W-1:0] = trace_mem[rd_slot];
      if (st.tfmt)
      begin
        trace_word[31:24] = {1'b0, st.tmode, st.tcnt};
      end
    end
  end
  assign status_word = {20'h0, st.tcnt, st.rx_full, st.tx_full, st.isr_act, st.halted,
                        st.state != dbg_pkg::ST_IDLE, st.halt_req};

  // ----------------------------------------------------------------
  // core domain: bus and cpu facing outputs
  // ----------------------------------------------------------------
  // grant only on an idle cpu bus, or steal one cycle in priority mode
  assign mem_req = (st.state == dbg_pkg::ST_BUS) && (!cpu_bus_busy || st.prio);
  assign cpu_stall = (st.state == dbg_pkg::ST_BUS) && cpu_bus_busy && st.prio;
  assign mem_we = cmd_code == `DBG_CMD_MEM_WR;
  assign mem_addr = st.cmd[`DBG_ADDR_LSB +: 12];
  assign mem_wdata = st.cmd[`DBG_DATA_LSB +: 32];
  assign fetch_hold = st.halt_req && !st.isr_act;
  assign pipe_stall = st.halted && !st.isr_act;
  // emulation environment only when chosen and a halt is requested
  // halted also counts, so the last halted cycle after a run keeps the emulation mask
  assign irq_take = |(irq_pend & ((st.env_sel && (st.halt_req || st.halted)) ?
                                  st.mask_emu : st.mask_norm));
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.hrdata;
  assign ahb_take = hsel && hready && htrans[1];

  // ----------------------------------------------------------------
  // core domain: next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.req_s1 = lk.req_tgl;
    next_st.req_s2 = st.req_s1;
    // command engine
    case (st.state)
      dbg_pkg::ST_IDLE:
      begin
        if (req_new)
        begin
          next_st.cmd = lk.word;
          case (lk.word[`DBG_CMD_LSB +: 4])
            `DBG_CMD_MEM_RD, `DBG_CMD_MEM_WR:
            begin
              next_st.state = dbg_pkg::ST_BUS;
            end
            `DBG_CMD_HALT:
            begin
              next_st.halt_req = 1'b1;
              next_st.ack_tgl = ~st.ack_tgl;
            end
            `DBG_CMD_RUN:
            begin
              next_st.halt_req = 1'b0;
              next_st.ack_tgl = ~st.ack_tgl;
            end
            `DBG_CMD_TRACE_RD:
            begin
              next_st.result = trace_word;
              next_st.ack_tgl = ~st.ack_tgl;
            end
            `DBG_CMD_CFG:
            begin
              next_st.ten = lk.word[`DBG_DATA_LSB + `DBG_CFG_TEN];
              next_st.tmode = lk.word[`DBG_DATA_LSB + `DBG_CFG_TMODE];
              next_st.tfmt = lk.word[`DBG_DATA_LSB + `DBG_CFG_TFMT];
              if (next_st.tmode != st.tmode)
              begin
                next_st.wptr = '0;
                next_st.tcnt = '0;
              end
              next_st.ack_tgl = ~st.ack_tgl;
            end
            `DBG_CMD_CHAN_RD:
            begin
              next_st.result = st.tx_word;
              next_st.tx_full = 1'b0;
              next_st.ack_tgl = ~st.ack_tgl;
            end
            `DBG_CMD_CHAN_WR:
            begin
              next_st.ack_tgl = ~st.ack_tgl;
            end
            `DBG_CMD_STATUS:
            begin
              next_st.result = status_word;
              next_st.ack_tgl = ~st.ack_tgl;
            end
            default:
            begin
              next_st.ack_tgl = ~st.ack_tgl;
            end
          endcase
        end
      end
      dbg_pkg::ST_BUS:
      begin
        if (mem_req)
        begin
          if (mem_we)
          begin
            next_st.state = dbg_pkg::ST_IDLE;
            next_st.ack_tgl = ~st.ack_tgl;
          end
          else
          begin
            next_st.state = dbg_pkg::ST_RDATA;
          end
        end
      end
      dbg_pkg::ST_RDATA:
      begin
        next_st.result = mem_rdata;
        next_st.ack_tgl = ~st.ack_tgl;
        next_st.state = dbg_pkg::ST_IDLE;
      end
      default:
      begin
        next_st.state = dbg_pkg::ST_IDLE;
      end
    endcase
    // stall only once the pipeline has drained
    next_st.halted = st.halt_req && (st.halted || pipe_empty);
    // interrupt nesting of the debug enable
    if (isr_entry)
    begin
      next_st.isr_act = 1'b1;
      next_st.saved_en = st.dbg_en;
    end
    // trace capture into the circular history
    if (trace_rec)
    begin
      next_st.wptr = (st.wptr + 5'd1) & 5'(depth - 6'd1);
      if (st.tcnt < depth)
      begin
        next_st.tcnt = st.tcnt + 6'd1;
      end
    end
    // pacing of the cpu to host channel
    if (st.pace != 8'h0)
    begin
      next_st.pace = st.pace - 8'h1;
    end
    // ahb: register read data is set up in the address phase
    next_st.ahb_wr = 1'b0;
    if (ahb_take)
    begin
      next_st.ahb_wr = hwrite && (haddr[31:8] == 24'h0); // unmapped writes ignored
      next_st.ahb_idx = haddr[7:2];
      next_st.hrdata = '0;
      if (haddr[31:8] == 24'h0 && !hwrite)
      begin
        case (haddr[7:2])
          `DBG_REG_CTRL: next_st.hrdata = {29'h0, st.env_sel, st.prio, st.dbg_en};
          `DBG_REG_STATUS: next_st.hrdata = status_word;
          `DBG_REG_MASK_NORM: next_st.hrdata = {24'h0, st.mask_norm};
          `DBG_REG_MASK_EMU: next_st.hrdata = {24'h0, st.mask_emu};
          `DBG_REG_CHAN_TX: next_st.hrdata = st.tx_word;
          `DBG_REG_CHAN_RX:
          begin
            next_st.hrdata = st.rx_word;
            next_st.rx_full = 1'b0;
          end
          default: next_st.hrdata = '0;
        endcase
      end
    end
    // ahb: write data phase
    if (st.ahb_wr)
    begin
      case (st.ahb_idx)
        `DBG_REG_CTRL:
        begin
          next_st.dbg_en = hwdata[`DBG_CTRL_EN];
          next_st.prio = hwdata[`DBG_CTRL_PRIO];
          next_st.env_sel = hwdata[`DBG_CTRL_ENV];
        end
        `DBG_REG_MASK_NORM: next_st.mask_norm = hwdata[7:0];
        `DBG_REG_MASK_EMU: next_st.mask_emu = hwdata[7:0];
        `DBG_REG_CHAN_TX:
        begin
          // a word too soon or onto a full slot is dropped
          if (!st.tx_full && st.pace == 8'h0)
          begin
            next_st.tx_word = hwdata;
            next_st.tx_full = 1'b1;
            next_st.pace = 8'(`DBG_CHAN_WORD_CYCLES);
          end
        end
        default:
        begin
        end
      endcase
    end
    // host write to the channel wins over a same-cycle cpu read
    if (req_new && lk.word[`DBG_CMD_LSB +: 4] == `DBG_CMD_CHAN_WR)
    begin
      next_st.rx_word = lk.word[`DBG_DATA_LSB +: 32];
      next_st.rx_full = 1'b1;
    end
    // return restores the debug enable over any write in the isr
    if (isr_return && st.isr_act)
    begin
      next_st.isr_act = 1'b0;
      next_st.dbg_en = st.saved_en;
    end
    if (!rstn)
    begin
      next_st = '0;
      next_st.state = dbg_pkg::ST_IDLE;
      next_st.dbg_en = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  // trace history storage, no reset needed
  always_ff @(posedge clk)
  begin
    if (trace_rec)
    begin
      trace_mem[st.wptr] <= pc;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_NO_STEAL: assert property (@(posedge clk) disable iff (!rstn)
    (mem_req && cpu_bus_busy) |-> st.prio)
    else $error("debug access took a busy bus outside priority mode");
  AST_STALL_ONE: assert property (@(posedge clk) disable iff (!rstn)
    cpu_stall |=> !cpu_stall)
    else $error("cpu stalled for more than one cycle");
  AST_STALL_GRANT: assert property (@(posedge clk) disable iff (!rstn)
    cpu_stall |-> (mem_req && st.prio))
    else $error("stall without a debug access");
  AST_READ_ACK: assert property (@(posedge clk) disable iff (!rstn)
    (st.state == dbg_pkg::ST_RDATA) |=> ($changed(st.ack_tgl) && st.result == $past(mem_rdata)))
    else $error("read data not returned to the link");
  AST_HALT_DRAIN: assert property (@(posedge clk) disable iff (!rstn)
    $rose(st.halted) |-> ($past(pipe_empty) && $past(st.halt_req)))
    else $error("pipeline stalled before it drained");
  AST_ISR_HALTED: assert property (@(posedge clk) disable iff (!rstn)
    (st.halted && st.env_sel && (irq_pend & st.mask_emu) != '0) |-> irq_take)
    else $error("enabled interrupt refused while halted");
  AST_ISR_RESTORE: assert property (@(posedge clk) disable iff (!rstn)
    (isr_return && st.isr_act) |=> (st.dbg_en == $past(st.saved_en)))
    else $error("debug enable not restored at return");
  AST_TRACE_DEPTH: assert property (@(posedge clk) disable iff (!rstn)
    st.tcnt <= depth)
    else $error("trace count beyond its depth");
  AST_TRACE_WRAP: assert property (@(posedge clk) disable iff (!rstn)
    (trace_rec && st.tcnt == depth && !req_new) |=>
      (st.tcnt == $past(st.tcnt) && st.wptr != $past(st.wptr)))
    else $error("full trace history did not wrap");
  AST_CHAN_PACE: assert property (@(posedge clk) disable iff (!rstn)
    $rose(st.tx_full) |-> (st.pace == 8'(`DBG_CHAN_WORD_CYCLES)))
    else $error("channel word accepted without pacing");

endmodule

// >>> sim/scan_emulator.sv
// Purpose: behavioural emulator at the far end of the scan link
// Assumes: one 48-bit frame per command, answer shifted out in the next frame
// Notes: tck stands still between frames but for short bursts with scan_sel low
`timescale 1ns/1ps
`include "dbg_cfg.svh"
module scan_emulator (
  output logic tck,
  output logic scan_sel,
  output logic scan_in,
  input wire logic scan_out
);
  int timeouts = 0;

  initial
  begin
    tck = 1'b0;
    scan_sel = 1'b0;
    scan_in = 1'b0;
  end

  // free tck edges, so the link side sees reset
  task automatic pulse(input int cnt);
    repeat (cnt)
    begin
      #32 tck = 1'b1;
      #32 tck = 1'b0;
    end
  endtask

  // bit k goes out before rise k+1, answer bit k is read after that rise
  task automatic frame(input logic [47:0] f, output logic [47:0] r);
    scan_sel = 1'b1;
    for (int k = 0; k < 48; k++)
    begin
      scan_in = f[k];
      #32 tck = 1'b1;
      #32 tck = 1'b0;
      r[k] = scan_out;
    end
    scan_sel = 1'b0;
    scan_in = ~f[47]; // released line must not show a stale bit
  endtask

  // command frame, then no-op polls until the answer is no longer busy
  task automatic xfer(input logic [3:0] c, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] res, output logic ok);
    logic [47:0] r;
    ok = 1'b0;
    res = 32'h0;
    frame({d, a, c}, r);
    for (int i = 0; i < 8 && !ok; i++)
    begin
      #200;
      // two edges carry the ack across; a stopped tck would leave busy stale
      pulse(2);
      frame({44'h0, `DBG_CMD_NOP}, r);
      ok = ~r[32];
      res = r[31:0];
    end
    if (!ok)
      timeouts++;
  endtask
endmodule

// >>> sim/onchip_debug_trace_unit_tb.sv
// Purpose: self-checking bench for the on-chip debug and trace unit
// Assumes: zero-wait register port, scan partner in scan_emulator
// Notes: register reads are checked by a monitor from a queue of notes
`timescale 1ns/1ps
`include "dbg_cfg.svh"
module onchip_debug_trace_unit_tb;
  logic clk, rstn, hsel, hwrite, hreadyout, hresp, tck, scan_sel, scan_in, scan_out;
  logic [31:0] haddr, hwdata, hrdata, mem_wdata, mem_rdata, res, e, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [11:0] mem_addr;
  logic [7:0] irq_pend;
  logic [23:0] pc, v;
  logic cpu_bus_busy, cpu_stall, mem_req, mem_we, pipe_empty, fetch_hold, pipe_stall;
  logic irq_take, isr_entry, isr_return, pc_valid, pc_disc, ok;
  logic prio_test = 1'b0;
  logic rd_ph = 1'b0;
  logic [31:0] mem [4096];
  logic [23:0] hist [40];
  logic [31:0] notes [$];
  int failures = 0, compares = 0, bus_clash = 0, stalls = 0, n, dep;
  int ag [3];
  wire logic hready;
  assign hready = hreadyout;

  onchip_debug_trace_unit DUT (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tck(tck),
    .scan_sel(scan_sel), .scan_in(scan_in), .scan_out(scan_out),
    .cpu_bus_busy(cpu_bus_busy), .cpu_stall(cpu_stall), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .pipe_empty(pipe_empty), .fetch_hold(fetch_hold), .pipe_stall(pipe_stall),
    .irq_pend(irq_pend), .irq_take(irq_take), .isr_entry(isr_entry),
    .isr_return(isr_return), .pc_valid(pc_valid), .pc_disc(pc_disc), .pc(pc)
  );
  scan_emulator emu (.tck(tck), .scan_sel(scan_sel), .scan_in(scan_in), .scan_out(scan_out));

  // ----------------------------------------------------------------
  // clock, memory model, monitors
  // ----------------------------------------------------------------
  always #12.5 clk = ~clk;

  // shared memory: data one clk after the request, inverted pattern when idle
  always @(posedge clk)
  begin
    mem_rdata <= ~mem_rdata;
    if (mem_req === 1'b1)
    begin
      mem_rdata <= mem[mem_addr];
      if (mem_we)
        mem[mem_addr] <= mem_wdata;
      if (cpu_bus_busy && cpu_stall !== 1'b1)
        bus_clash++;
    end
    if (cpu_stall === 1'b1)
      stalls++;
    cpu_bus_busy <= prio_test | 1'($urandom_range(1));
  end

  // data-phase monitor: each read result is compared with the oldest note
  always @(posedge clk)
  begin
    if (rd_ph && hready)
    begin
      if (notes.size() == 0)
        check(1'b1, 1'b0, "read without note");
      else
        check(hrdata, notes.pop_front(), "register read");
      check(hresp, 1'b0, "response not okay");
    end
    rd_ph = hsel && htrans[1] && !hwrite && hready;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // next edge with hready high, bounded so a stuck slave ends the run
  task automatic edge_rdy();
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1 && k < 50)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 50)
    begin
      failures++;
      give_verdict();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'b010;
    edge_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    edge_rdy();
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    notes.push_back(exp);
    ahb(1'b0, a, 32'h0);
  endtask

  task automatic give_verdict();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    {hsel, hwrite, haddr, htrans, hwdata, hsize} = '0;
    {pipe_empty, irq_pend, isr_entry, isr_return, pc_valid, pc_disc, pc} = '0;
    {mem_rdata, cpu_bus_busy} = '0;
    void'($urandom(32'ha9f0eed7));
    foreach (mem[i])
      mem[i] = $urandom;
    fork
      repeat (20) @(posedge clk);
      emu.pulse(4);
    join
    rstn <= 1'b1;
    emu.pulse(3);
    @(posedge clk);
    // register defaults, access and an unmapped place
    rd(8'h00, 32'h1);
    rd(8'h04, 32'h0);
    ahb(1'b1, 8'h08, 32'ha5);
    ahb(1'b1, 8'h0c, 32'h3c);
    rd(8'h08, 32'ha5);
    rd(8'h40, 32'h0);
    // normal environment: each pending line against the normal mask
    for (int b = 0; b < 8; b++)
    begin
      @(posedge clk);
      irq_pend <= 8'(1 << b);
      @(negedge clk);
      check(irq_take, 32'(8'ha5 >> b) & 1, "normal irq");
    end
    // memory access while the cpu runs, bus busy at random
    d = $urandom;
    emu.xfer(`DBG_CMD_MEM_WR, 12'h123, d, res, ok);
    check(ok, 1'b1, "scan write");
    check(mem[12'h123], d, "memory write");
    emu.xfer(`DBG_CMD_MEM_RD, 12'h0ab, 32'h0, res, ok);
    check(res, mem[12'h0ab], "memory read");
    check(pipe_stall, 1'b0, "cpu kept running");
    // priority mode: bus never free, exactly one stolen cycle
    ahb(1'b1, 8'h00, 32'h3);
    prio_test = 1'b1;
    stalls = 0;
    emu.xfer(`DBG_CMD_MEM_RD, 12'h077, 32'h0, res, ok);
    check(res, mem[12'h077], "priority read");
    check(stalls, 1, "stall cycles");
    prio_test = 1'b0;
    // halt: pipeline drains first, then the emulation environment applies
    ahb(1'b1, 8'h00, 32'h5);
    emu.xfer(`DBG_CMD_HALT, 12'h0, 32'h0, res, ok);
    check({fetch_hold, pipe_stall}, 2'b10, "halt before drain");
    @(posedge clk);
    pipe_empty <= 1'b1;
    n = 0;
    while (pipe_stall !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check(pipe_stall, 1'b1, "halt after drain");
    rd(8'h04, 32'h5);
    irq_pend <= 8'h08;
    @(negedge clk);
    check(irq_take, 1'b1, "emulation irq");
    @(posedge clk);
    irq_pend <= 8'h01;
    @(negedge clk);
    check(irq_take, 1'b0, "emulation mask");
    // service routine while halted; debug enable saved and restored
    @(posedge clk);
    isr_entry <= 1'b1;
    @(posedge clk);
    isr_entry <= 1'b0;
    ahb(1'b1, 8'h00, 32'h4);
    check(pipe_stall, 1'b0, "isr runs");
    rd(8'h00, 32'h4);
    @(posedge clk);
    isr_return <= 1'b1;
    @(posedge clk);
    isr_return <= 1'b0;
    rd(8'h00, 32'h5);
    emu.xfer(`DBG_CMD_RUN, 12'h0, 32'h0, res, ok);
    check({fetch_hold, pipe_stall}, 2'b00, "resumed");
    ahb(1'b1, 8'h00, 32'h1);
    // trace: sequential format 0, then discontinuity format 1
    for (int m = 0; m < 2; m++)
    begin
      emu.xfer(`DBG_CMD_CFG, 12'h0, {29'h0, m[0], m[0], 1'b1}, res, ok);
      n = 0;
      for (int i = 0; i < 40; i++)
      begin
        @(posedge clk);
        v = 24'($urandom);
        pc_valid <= 1'b1;
        pc <= v;
        pc_disc <= i[0];
        if (m == 0 || i[0])
          hist[n++] = v;
      end
      @(posedge clk);
      pc_valid <= 1'b0;
      dep = m ? 16 : 32;
      ag = '{0, dep - 1, dep};
      foreach (ag[j])
      begin
        emu.xfer(`DBG_CMD_TRACE_RD, 12'(ag[j]), 32'h0, res, ok);
        e = (ag[j] < dep) ? {m ? {2'b01, 6'(dep)} : 8'h00, hist[n - 1 - ag[j]]} : 32'h0;
        check(res, e, "trace entry");
      end
    end
    // data channel both ways; second cpu word dropped while the first waits
    d = $urandom;
    emu.xfer(`DBG_CMD_CHAN_WR, 12'h0, d, res, ok);
    rd(8'h14, d);
    e = $urandom;
    ahb(1'b1, 8'h10, e);
    ahb(1'b1, 8'h10, ~e);
    emu.xfer(`DBG_CMD_CHAN_RD, 12'h0, 32'h0, res, ok);
    check(res, e, "channel to host");
    check(bus_clash, 0, "bus shared with cpu");
    check(emu.timeouts, 0, "scan answers in time");
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
